// >>> hw/nvm_pkg.sv
package nvm_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int WRITE_TIME_NS_DEFAULT = 2000000;
	localparam int PROG_READ_CYCLES = 2;

	localparam logic [8:0] OFS_ACCESS_CONTROL = 9'h18c;
	localparam logic [8:0] OFS_UNLOCK_PORT = 9'h18d;
	localparam logic [8:0] OFS_DATA_LOW = 9'h10c;
	localparam logic [8:0] OFS_ADDR_LOW = 9'h10d;
	localparam logic [8:0] OFS_DATA_HIGH = 9'h10e;
	localparam logic [8:0] OFS_ADDR_HIGH = 9'h10f;

	localparam int SEL_BIT = 7;
	localparam int ABORT_BIT = 3;
	localparam int PERMIT_BIT = 2;
	localparam int WR_BIT = 1;
	localparam int RD_BIT = 0;

	localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
	localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;

	localparam int DATA_WIDTH = 8;
	localparam int DATA_DEPTH = 64;
	localparam int DATA_AW = 6;
	localparam int PROG_WIDTH = 14;
	localparam int PROG_DEPTH = 2048;
	localparam int PROG_AW = 11;
	localparam int ADDR_HI_WIDTH = 5;

	typedef logic [DATA_AW-1:0] data_addr_t;
	typedef logic [DATA_WIDTH-1:0] data_word_t;
	typedef logic [PROG_AW-1:0] prog_addr_t;
	typedef logic [PROG_WIDTH-1:0] prog_word_t;
	typedef logic [$clog2(PROG_READ_CYCLES)-1:0] rd_cnt_t;

	typedef enum logic [1:0] {UNLOCK_IDLE, UNLOCK_GOT_FIRST, UNLOCK_ARMED} unlock_e;

	typedef struct packed {
		logic [8:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} sfr_req_s;

	typedef struct packed {
		logic sel;
		logic abort;
		logic permit;
		logic wr;
		logic rd;
		rd_cnt_t rd_cnt;
		unlock_e unlock;
		logic [DATA_WIDTH-1:0] data_lo;
		logic [PROG_WIDTH-DATA_WIDTH-1:0] data_hi;
		logic [7:0] addr_lo;
		logic [ADDR_HI_WIDTH-1:0] addr_hi;
		logic tgt_sel;
		prog_addr_t tgt_addr;
		prog_word_t tgt_data;
		logic erase_now;
		logic done;
		logic [7:0] rdata;
		logic irq_pend;
		logic resume;
		logic bulk_rej;
	} ctrl_s;

	localparam ctrl_s CTRL_RESET = '0;
endpackage : nvm_pkg

// >>> hw/nvm_array.sv
`timescale 1ns/1ps
module nvm_array #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 64,
	localparam int AW = $clog2(DEPTH)
) (
	input wire logic mclk,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data,
	input wire logic erase,
	input wire logic prog_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	if ((1 << AW) != DEPTH || WIDTH < 1)
	begin : g_bad_shape
		$error("nvm_array depth must be a power of two");
	end

	// Cells only move from one to zero when programmed, hence the erase first
	always_ff @(posedge mclk)
	begin
		if (erase)
		begin
			mem[wr_addr] <= '1;
		end
		else if (prog_en)
		begin
			mem[wr_addr] <= mem[wr_addr] & wr_data;
		end
	end

	assign rd_data = mem[rd_addr];
endmodule : nvm_array

// >>> hw/nvm_write_timer.sv
`timescale 1ns/1ps
module nvm_write_timer #(
	parameter int CYCLES = 1,
	localparam int CW = $clog2(CYCLES + 1)
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire logic cancel,
	output logic busy,
	output logic expire
);
	typedef struct packed {
		logic [CW-1:0] cnt;
	} timer_s;

	timer_s state_ff;
	timer_s nxt_state;

	if (CYCLES < 1)
	begin : g_bad_cycles
		$error("nvm_write_timer needs at least one cycle");
	end

	always_comb
	begin
		nxt_state = state_ff;
		if (cancel)
		begin
			nxt_state.cnt = '0;
		end
		else if (start)
		begin
			nxt_state.cnt = CW'(CYCLES);
		end
		else if (state_ff.cnt != '0)
		begin
			nxt_state.cnt = state_ff.cnt - 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign busy = state_ff.cnt != '0;
	assign expire = state_ff.cnt == CW'(1);
endmodule : nvm_write_timer

// >>> hw/nvm_access_ctrl.sv
`timescale 1ns/1ps
module nvm_access_ctrl #(
	parameter int WRITE_TIME_NS = nvm_pkg::WRITE_TIME_NS_DEFAULT
) (
	input wire logic mclk,
	input wire logic rst,
	input wire nvm_pkg::sfr_req_s sfr_req,
	output logic [7:0] sfr_rdata,
	input wire logic external_reset_pin,
	input wire logic watchdog_timeout,
	input wire logic write_done_clr,
	output logic write_done_flag,
	input wire logic irq_req,
	output logic irq_to_core,
	output logic cpu_stall,
	input wire logic bulk_erase_req,
	output logic bulk_erase_rejected
);
	localparam int WRITE_CYCLES =
		(WRITE_TIME_NS + nvm_pkg::CLK_PERIOD_NS - 1) / nvm_pkg::CLK_PERIOD_NS;

	nvm_pkg::ctrl_s state_ff;
	nvm_pkg::ctrl_s nxt_state;
	logic soft_rst;
	logic start_write;
	logic busy;
	logic expire;
	logic write_ok;
	logic irq_gate;
	nvm_pkg::data_word_t ee_q;
	nvm_pkg::prog_word_t pg_q;

	// Erase owns the first write cycle, so programming needs at least one more
	if (WRITE_CYCLES < 2)
	begin : g_bad_time
		$error("write time must cover at least two clocks");
	end

	assign soft_rst = external_reset_pin | watchdog_timeout;
	// An expiry swallowed by a reset in the same cycle counts as an aborted write
	assign write_ok = expire & ~soft_rst;

	nvm_write_timer #(
		.CYCLES(WRITE_CYCLES)
	) u_timer (
		.mclk(mclk),
		.rst(rst),
		.start(start_write),
		.cancel(soft_rst),
		.busy(busy),
		.expire(expire)
	);

	nvm_array #(
		.WIDTH(nvm_pkg::DATA_WIDTH),
		.DEPTH(nvm_pkg::DATA_DEPTH)
	) u_data_mem (
		.mclk(mclk),
		.rd_addr(nvm_pkg::data_addr_t'(state_ff.addr_lo)),
		.rd_data(ee_q),
		.erase(state_ff.erase_now & ~state_ff.tgt_sel),
		.prog_en(write_ok & ~state_ff.tgt_sel),
		.wr_addr(nvm_pkg::data_addr_t'(state_ff.tgt_addr)),
		.wr_data(nvm_pkg::data_word_t'(state_ff.tgt_data))
	);

	nvm_array #(
		.WIDTH(nvm_pkg::PROG_WIDTH),
		.DEPTH(nvm_pkg::PROG_DEPTH)
	) u_prog_mem (
		.mclk(mclk),
		.rd_addr(nvm_pkg::prog_addr_t'({state_ff.addr_hi, state_ff.addr_lo})),
		.rd_data(pg_q),
		.erase(state_ff.erase_now & state_ff.tgt_sel),
		.prog_en(write_ok & state_ff.tgt_sel),
		.wr_addr(state_ff.tgt_addr),
		.wr_data(state_ff.tgt_data)
	);

	always_comb
	begin
		logic [7:0] ctrl_view;
		logic op_busy;
		logic [7:0] wd;
		ctrl_view = 8'h00;
		op_busy = state_ff.rd | state_ff.wr;
		wd = sfr_req.wdata;
		nxt_state = state_ff;
		start_write = 1'b0;
		nxt_state.erase_now = 1'b0;
		nxt_state.bulk_rej = bulk_erase_req;

		ctrl_view[nvm_pkg::SEL_BIT] = state_ff.sel;
		ctrl_view[nvm_pkg::ABORT_BIT] = state_ff.abort;
		ctrl_view[nvm_pkg::PERMIT_BIT] = state_ff.permit;
		ctrl_view[nvm_pkg::WR_BIT] = state_ff.wr;
		ctrl_view[nvm_pkg::RD_BIT] = state_ff.rd;

		nxt_state.rdata = 8'h00;
		if (sfr_req.rd)
		begin
			if (sfr_req.addr == nvm_pkg::OFS_ACCESS_CONTROL)
			begin
				nxt_state.rdata = ctrl_view;
			end
			else if (sfr_req.addr == nvm_pkg::OFS_DATA_LOW)
			begin
				nxt_state.rdata = state_ff.data_lo;
			end
			else if (sfr_req.addr == nvm_pkg::OFS_DATA_HIGH)
			begin
				nxt_state.rdata = {2'b00, state_ff.data_hi};
			end
			else if (sfr_req.addr == nvm_pkg::OFS_ADDR_LOW)
			begin
				nxt_state.rdata = state_ff.addr_lo;
			end
			else if (sfr_req.addr == nvm_pkg::OFS_ADDR_HIGH)
			begin
				nxt_state.rdata = {3'b000, state_ff.addr_hi};
			end
		end

		if (sfr_req.wr)
		begin
			// Any write outside the exact key order drops the sequence
			nxt_state.unlock = nvm_pkg::UNLOCK_IDLE;
			if (sfr_req.addr == nvm_pkg::OFS_UNLOCK_PORT)
			begin
				if (wd == nvm_pkg::UNLOCK_KEY_FIRST)
				begin
					nxt_state.unlock = nvm_pkg::UNLOCK_GOT_FIRST;
				end
				else if (wd == nvm_pkg::UNLOCK_KEY_SECOND &&
					state_ff.unlock == nvm_pkg::UNLOCK_GOT_FIRST)
				begin
					nxt_state.unlock = nvm_pkg::UNLOCK_ARMED;
				end
			end
			else if (sfr_req.addr == nvm_pkg::OFS_DATA_LOW)
			begin
				nxt_state.data_lo = wd;
			end
			else if (sfr_req.addr == nvm_pkg::OFS_DATA_HIGH)
			begin
				nxt_state.data_hi = wd[5:0];
			end
			else if (sfr_req.addr == nvm_pkg::OFS_ADDR_LOW)
			begin
				nxt_state.addr_lo = wd;
			end
			else if (sfr_req.addr == nvm_pkg::OFS_ADDR_HIGH)
			begin
				nxt_state.addr_hi = wd[4:0];
			end
			else if (sfr_req.addr == nvm_pkg::OFS_ACCESS_CONTROL)
			begin
				nxt_state.permit = wd[nvm_pkg::PERMIT_BIT];
				nxt_state.abort = wd[nvm_pkg::ABORT_BIT];
				if (!op_busy)
				begin
					nxt_state.sel = wd[nvm_pkg::SEL_BIT];
				end
				// Old permit value is used, so one write cannot both permit and start
				if (wd[nvm_pkg::WR_BIT] && !op_busy && state_ff.permit &&
					state_ff.unlock == nvm_pkg::UNLOCK_ARMED)
				begin
					start_write = 1'b1;
					nxt_state.wr = 1'b1;
					nxt_state.erase_now = 1'b1;
					nxt_state.tgt_sel = wd[nvm_pkg::SEL_BIT];
					nxt_state.tgt_addr = nvm_pkg::prog_addr_t'({state_ff.addr_hi, state_ff.addr_lo});
					nxt_state.tgt_data = {state_ff.data_hi, state_ff.data_lo};
				end
				else if (wd[nvm_pkg::RD_BIT] && !op_busy)
				begin
					nxt_state.rd = 1'b1;
					nxt_state.rd_cnt = '0;
				end
			end
		end

		if (state_ff.rd)
		begin
			if (!state_ff.sel)
			begin
				nxt_state.data_lo = ee_q;
				nxt_state.rd = 1'b0;
			end
			else if (state_ff.rd_cnt == nvm_pkg::rd_cnt_t'(nvm_pkg::PROG_READ_CYCLES - 1))
			begin
				nxt_state.data_lo = pg_q[7:0];
				nxt_state.data_hi = pg_q[13:8];
				nxt_state.rd = 1'b0;
				nxt_state.rd_cnt = '0;
			end
			else
			begin
				nxt_state.rd_cnt = state_ff.rd_cnt + 1'b1;
			end
		end

		if (write_ok)
		begin
			nxt_state.wr = 1'b0;
		end

		// A completion in the clearing cycle is kept
		nxt_state.done = (state_ff.done & ~write_done_clr) | write_ok;

		if (soft_rst)
		begin
			if (state_ff.wr)
			begin
				nxt_state.abort = 1'b1;
			end
			nxt_state.wr = 1'b0;
			nxt_state.rd = 1'b0;
			nxt_state.rd_cnt = '0;
			nxt_state.permit = 1'b0;
			nxt_state.unlock = nvm_pkg::UNLOCK_IDLE;
			// A start cancelled in its own cycle must not leave the target erased
			nxt_state.erase_now = 1'b0;
		end

		// The stalled instruction runs one cycle before any queued interrupt
		nxt_state.resume = cpu_stall & ~nxt_state.wr;
		nxt_state.irq_pend = irq_gate & (state_ff.irq_pend | irq_req);
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_ff <= nvm_pkg::CTRL_RESET;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign cpu_stall = state_ff.wr & state_ff.tgt_sel;
	assign irq_gate = cpu_stall | state_ff.resume;
	assign irq_to_core = ~irq_gate & (irq_req | state_ff.irq_pend);
	assign sfr_rdata = state_ff.rdata;
	assign write_done_flag = state_ff.done;
	assign bulk_erase_rejected = state_ff.bulk_rej;

	a_unlock_reads_zero: assert property (@(posedge mclk) disable iff (rst)
		sfr_req.rd && sfr_req.addr == nvm_pkg::OFS_UNLOCK_PORT |=> sfr_rdata == 8'h00)
		else $error("unlock port read returned nonzero");

	a_select_frozen: assert property (@(posedge mclk) disable iff (rst)
		(state_ff.rd || state_ff.wr) |=> $stable(state_ff.sel))
		else $error("select bit changed during an operation");

	a_strobe_held: assert property (@(posedge mclk) disable iff (rst)
		state_ff.wr && !expire && !soft_rst |=> state_ff.wr)
		else $error("write strobe dropped early");

	a_permit_before: assert property (@(posedge mclk) disable iff (rst)
		$rose(state_ff.wr) |-> $past(state_ff.permit))
		else $error("write started without earlier permit");

	a_unlock_order: assert property (@(posedge mclk) disable iff (rst)
		$rose(state_ff.wr) |-> $past(state_ff.unlock) == nvm_pkg::UNLOCK_ARMED)
		else $error("write started without unlock keys");

	a_done_on_expire: assert property (@(posedge mclk) disable iff (rst)
		write_ok |=> !state_ff.wr && write_done_flag)
		else $error("expiry did not finish the write");

	a_done_sticky: assert property (@(posedge mclk) disable iff (rst)
		write_done_flag && !write_done_clr |=> write_done_flag)
		else $error("done flag cleared without software");

	a_abort_on_reset: assert property (@(posedge mclk) disable iff (rst)
		state_ff.wr && soft_rst |=> state_ff.abort && !state_ff.wr && $stable(state_ff.sel))
		else $error("interrupted write not flagged");

	a_keep_address: assert property (@(posedge mclk) disable iff (rst)
		soft_rst && !sfr_req.wr |=> $stable(state_ff.addr_lo) && $stable(state_ff.data_lo))
		else $error("reset disturbed address or data");

	a_data_read_next: assert property (@(posedge mclk) disable iff (rst)
		state_ff.rd && !state_ff.sel |=> !state_ff.rd && state_ff.data_lo == $past(ee_q))
		else $error("data read not ready next cycle");

	a_prog_read_two: assert property (@(posedge mclk) disable iff (rst || soft_rst)
		$rose(state_ff.rd) && state_ff.sel |-> state_ff.rd [*2] ##1 !state_ff.rd)
		else $error("program read did not take two cycles");

	a_irq_queued: assert property (@(posedge mclk) disable iff (rst)
		cpu_stall && irq_req |=> !irq_to_core ##0 (cpu_stall || state_ff.resume || state_ff.irq_pend))
		else $error("interrupt lost or delivered during stall");

	a_bulk_refused: assert property (@(posedge mclk) disable iff (rst)
		bulk_erase_req |=> bulk_erase_rejected)
		else $error("bulk erase request not refused");

	a_no_irq_stalled: assert property (@(posedge mclk) disable iff (rst)
		cpu_stall |-> !irq_to_core)
		else $error("interrupt passed to a stalled core");

	a_high_reads_zero: assert property (@(posedge mclk) disable iff (rst)
		sfr_req.rd && sfr_req.addr == nvm_pkg::OFS_DATA_HIGH |=> sfr_rdata[7:6] == 2'b00)
		else $error("unused high data bits read nonzero");

	a_done_needs_write: assert property (@(posedge mclk) disable iff (rst)
		$rose(write_done_flag) |-> $past(state_ff.wr))
		else $error("done flag set without a running write");

	a_prog_read_busy: assert property (@(posedge mclk) disable iff (rst)
		state_ff.rd && state_ff.sel && state_ff.rd_cnt == '0 && !soft_rst |=> state_ff.rd)
		else $error("program read ended after one cycle");

	a_erase_first: assert property (@(posedge mclk) disable iff (rst)
		$rose(state_ff.wr) |-> state_ff.erase_now)
		else $error("write started without erasing the target");
endmodule : nvm_access_ctrl

// >>> verification/nvm_host_model.sv
`timescale 1ns/1ps
module nvm_host_model (
	input wire logic mclk,
	output nvm_pkg::sfr_req_s sfr_req,
	input wire logic [7:0] sfr_rdata
);
	initial
	begin
		sfr_req = '0;
	end

	// Released bus shows inverted values so a stale address or data never looks valid
	task automatic sfr_wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge mclk);
		#1;
		sfr_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
	endtask : sfr_wr

	task automatic sfr_rd(input logic [8:0] a, output logic [7:0] d);
		@(posedge mclk);
		#1;
		sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge mclk);
		#1;
		sfr_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
		d = sfr_rdata;
	endtask : sfr_rd

	task automatic unlock_write(input logic [7:0] ctl);
		sfr_wr(nvm_pkg::OFS_UNLOCK_PORT, nvm_pkg::UNLOCK_KEY_FIRST);
		sfr_wr(nvm_pkg::OFS_UNLOCK_PORT, nvm_pkg::UNLOCK_KEY_SECOND);
		sfr_wr(nvm_pkg::OFS_ACCESS_CONTROL, ctl);
	endtask : unlock_write
endmodule : nvm_host_model

// >>> verification/eeprom_flash_access_ctrl_tb_top.sv
`timescale 1ns/1ps
module eeprom_flash_access_ctrl_tb_top;
	localparam int WR_NS = 80;
	localparam int WR_CYC = WR_NS / nvm_pkg::CLK_PERIOD_NS;
	localparam logic [8:0] CTL = nvm_pkg::OFS_ACCESS_CONTROL;
	localparam logic [8:0] KEY = nvm_pkg::OFS_UNLOCK_PORT;
	localparam logic [8:0] DLO = nvm_pkg::OFS_DATA_LOW;
	localparam logic [8:0] DHI = nvm_pkg::OFS_DATA_HIGH;
	localparam logic [8:0] ALO = nvm_pkg::OFS_ADDR_LOW;
	localparam logic [8:0] AHI = nvm_pkg::OFS_ADDR_HIGH;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	nvm_pkg::sfr_req_s sfr_req;
	logic [7:0] sfr_rdata;
	logic external_reset_pin = 1'b0;
	logic watchdog_timeout = 1'b0;
	logic write_done_clr = 1'b0;
	logic write_done_flag;
	logic irq_req = 1'b0;
	logic irq_to_core;
	logic cpu_stall;
	logic bulk_erase_req = 1'b0;
	logic bulk_erase_rejected;
	int mismatches = 0;
	int n_checks = 0;

	always #4 mclk = ~mclk;

	nvm_access_ctrl #(.WRITE_TIME_NS(WR_NS)) i_nvm_access_ctrl (
		.mclk(mclk),
		.rst(rst),
		.sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata),
		.external_reset_pin(external_reset_pin),
		.watchdog_timeout(watchdog_timeout),
		.write_done_clr(write_done_clr),
		.write_done_flag(write_done_flag),
		.irq_req(irq_req),
		.irq_to_core(irq_to_core),
		.cpu_stall(cpu_stall),
		.bulk_erase_req(bulk_erase_req),
		.bulk_erase_rejected(bulk_erase_rejected)
	);

	nvm_host_model i_nvm_host_model (
		.mclk(mclk),
		.sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata)
	);

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	task automatic w(input logic [8:0] a, input logic [7:0] d);
		i_nvm_host_model.sfr_wr(a, d);
	endtask : w

	task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_nvm_host_model.sfr_rd(a, d);
		check(d, exp);
	endtask : rd_chk

	task automatic wait_done(output int n);
		n = 0;
		while (write_done_flag !== 1'b1 && n < 40)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
	endtask : wait_done

	task automatic clear_done();
		write_done_clr = 1'b1;
		@(posedge mclk);
		#1;
		write_done_clr = 1'b0;
	endtask : clear_done

	// Addresses stay inside the implemented range, loaded before the unlock keys
	task automatic start_wr(input logic sel, input logic [7:0] ah, input logic [7:0] al,
			input logic [7:0] dh, input logic [7:0] dl);
		w(AHI, ah);
		w(ALO, al);
		w(DHI, dh);
		w(DLO, dl);
		w(CTL, {sel, 7'h04});
		i_nvm_host_model.unlock_write({sel, 7'h06});
	endtask : start_wr

	task automatic read_back(input logic sel, input int waits);
		w(DLO, 8'h00);
		w(DHI, 8'h00);
		w(CTL, {sel, 7'h01});
		repeat (waits) @(posedge mclk);
	endtask : read_back

	initial
	begin
		#100000;
		mismatches++;
		tally_and_finish();
	end

	initial
	begin
		int n;
		repeat (4) @(posedge mclk);
		#1;
		rst = 1'b0;
		rd_chk(CTL, 8'h00);
		rd_chk(KEY, 8'h00);
		rd_chk(9'h000, 8'h00);
		w(CTL, 8'hf0);
		rd_chk(CTL, 8'h80);
		w(KEY, 8'h5a);
		rd_chk(KEY, 8'h00);
		w(AHI, 8'hff);
		rd_chk(AHI, 8'h1f);
		w(DHI, 8'hff);
		rd_chk(DHI, 8'h3f);
		// Second value needs erase before programming to read back exactly
		for (int i = 0; i < 2; i++)
		begin
			start_wr(1'b0, 8'h00, 8'h3f, 8'h00, i ? 8'hc3 : 8'h3c);
			wait_done(n);
			check(8'(n), 8'(WR_CYC));
			rd_chk(CTL, 8'h04);
			check(write_done_flag, 8'h01);
			clear_done();
			check(write_done_flag, 8'h00);
			read_back(1'b0, 1);
			rd_chk(DLO, i ? 8'hc3 : 8'h3c);
			rd_chk(CTL, 8'h00);
		end
		for (int i = 0; i < 2; i++)
		begin
			w(CTL, 8'h00);
			if (i == 0)
				i_nvm_host_model.unlock_write(8'h06);
			else
			begin
				w(CTL, 8'h04);
				w(KEY, nvm_pkg::UNLOCK_KEY_FIRST);
				w(KEY, 8'h12);
				w(KEY, nvm_pkg::UNLOCK_KEY_SECOND);
				w(CTL, 8'h06);
			end
			repeat (WR_CYC + 4) @(posedge mclk);
			#1;
			check(write_done_flag, 8'h00);
			rd_chk(CTL, 8'h04);
		end
		start_wr(1'b1, 8'h07, 8'hff, 8'hff, 8'ha5);
		@(posedge mclk);
		#1;
		check(cpu_stall, 8'h01);
		irq_req = 1'b1;
		#1;
		check(irq_to_core, 8'h00);
		w(CTL, 8'h04);
		// Request withdrawn mid-stall, so delivery must come from the queue
		irq_req = 1'b0;
		rd_chk(CTL, 8'h86);
		wait_done(n);
		check(8'(n), 8'(WR_CYC - 5));
		check(cpu_stall, 8'h00);
		check(irq_to_core, 8'h00);
		@(posedge mclk);
		#1;
		check(irq_to_core, 8'h01);
		clear_done();
		check(irq_to_core, 8'h00);
		read_back(1'b1, nvm_pkg::PROG_READ_CYCLES);
		rd_chk(DLO, 8'ha5);
		rd_chk(DHI, 8'h3f);
		for (int i = 0; i < 2; i++)
		begin
			start_wr(1'b1, 8'h00, 8'h12, 8'h00, 8'h00);
			@(posedge mclk);
			#1;
			external_reset_pin = (i == 0);
			watchdog_timeout = (i == 1);
			@(posedge mclk);
			#1;
			external_reset_pin = 1'b0;
			watchdog_timeout = 1'b0;
			rd_chk(CTL, 8'h88);
			rd_chk(ALO, 8'h12);
			check(write_done_flag, 8'h00);
			w(CTL, 8'h80);
		end
		bulk_erase_req = 1'b1;
		@(posedge mclk);
		#1;
		bulk_erase_req = 1'b0;
		check(bulk_erase_rejected, 8'h01);
		w(ALO, 8'h3f);
		read_back(1'b0, 1);
		rd_chk(DLO, 8'hc3);
		tally_and_finish();
	end
endmodule : eeprom_flash_access_ctrl_tb_top
